/* File: verilog/fct_timer.sv */
/*
 * Periodic countdown timer with AXI4-Lite registers and an
 * open-drain shared interrupt pin.
 * Assumes serial clock and foreign interrupt arrive asynchronously.
 */
`timescale 1ns/1ps
`include "fct_defines.svh"

// ==========================================================
module fct_timer #(
  parameter int CYC_4096  = `FCT_SRC_CYC,
  parameter int RTN_SHORT = `FCT_RTN_SHORT_CYC,
  parameter int RTN_LONG  = `FCT_RTN_LONG_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link
  input  wire logic        serial_clk,
  input  wire logic        other_irq,
  // Interrupt pin, open drain
  input  wire logic        irq_n_i,
  output logic             irq_n_o,
  output logic             irq_n_oe
);

  typedef struct packed {
    logic       awr;
    logic       wr;
    logic       aw_h;
    logic       w_h;
    logic [3:0] aw_i;
    logic [7:0] wd;
    logic       ws;
    logic       bv;
    logic       berr;
    logic       arr;
    logic       rv;
    logic [7:0] rd;
    logic       rerr;
    logic [7:0] pre_lo;
    logic [3:0] pre_hi;
    logic       te;
    logic [1:0] tsel;
    logic       tf;
    logic       timer_interrupt_enable;
    logic       halt;
    logic       crst;
    logic       pend;
    logic       run;
    logic [11:0] cnt;
    logic [14:0] pre;
    logic [5:0] d64;
    logic [11:0] sec;
    logic [11:0] hz;
    logic [5:0] mn;
    logic       tirq;
    logic [19:0] rtn;
    logic       oe;
    logic       sc1;
    logic       sc2;
    logic       sc3;
    logic       oi1;
    logic       oi2;
  } fct_state_s;

  fct_state_s st_ff;
  fct_state_s nxt_st;

  logic [11:0] preset;
  logic        stopped;
  logic        t4096;
  logic        t64;
  logic        t1;
  logic        tmin;
  logic        src_tick;
  logic        ev;
  logic        sclk_fall;

  assign preset    = {st_ff.pre_hi, st_ff.pre_lo};
  assign stopped   = st_ff.halt | st_ff.crst;
  assign t4096     = !stopped && (st_ff.pre == 15'(CYC_4096 - 1));
  assign t64       = t4096 && (st_ff.d64 == `FCT_DIV64);
  assign t1        = t4096 && (st_ff.hz == `FCT_DIV1HZ);
  assign tmin      = t4096 && (st_ff.sec == `FCT_DIV1HZ) && (st_ff.mn == `FCT_DIVMIN);
  assign sclk_fall = st_ff.sc3 && !st_ff.sc2;

  always_comb begin
    unique case (fct_pkg::fct_src_e'(st_ff.tsel))
      fct_pkg::FCT_SRC_4096HZ: src_tick = t4096;
      fct_pkg::FCT_SRC_64HZ:   src_tick = t64;
      fct_pkg::FCT_SRC_1HZ:    src_tick = t1;
      fct_pkg::FCT_SRC_1_60HZ: src_tick = tmin;
    endcase
  end

  // event on the tick at count 1, which reloads the preset
  assign ev = st_ff.run && src_tick && (st_ff.cnt == 12'h001);

  always_comb begin
    logic [7:0] rv8;
    logic       hit;
    logic       wdo;
    rv8 = 8'h00;
    hit = 1'b1;
    wdo = 1'b0;
    nxt_st = st_ff;

    // Two flops before any reader
    nxt_st.sc1 = serial_clk;
    nxt_st.sc2 = st_ff.sc1;
    nxt_st.sc3 = st_ff.sc2;
    nxt_st.oi1 = other_irq;
    nxt_st.oi2 = st_ff.oi1;

    // ========================================================
    // Time base; calendar runs free of the timer start
    if (!stopped) begin
      nxt_st.pre = t4096 ? 15'h0000 : 15'(st_ff.pre + 15'h0001);
    end
    if (t4096) begin
      nxt_st.d64 = 6'(st_ff.d64 + 6'h01);
      nxt_st.sec = 12'(st_ff.sec + 12'h001);
      nxt_st.hz  = 12'(st_ff.hz + 12'h001);
      if (st_ff.sec == `FCT_DIV1HZ) begin
        nxt_st.mn = (st_ff.mn == `FCT_DIVMIN) ? 6'h00 : 6'(st_ff.mn + 6'h01);
      end
    end

    // ========================================================
    // Countdown
    // halt or reset freezes counting
    if (st_ff.run && src_tick) begin
      if (st_ff.cnt <= 12'h001) begin
        nxt_st.cnt = preset;
      end else begin
        nxt_st.cnt = 12'(st_ff.cnt - 12'h001);
      end
    end
    // start on serial clock falling edge
    if (st_ff.pend && sclk_fall) begin
      nxt_st.pend = 1'b0;
      nxt_st.run  = 1'b1;
      nxt_st.cnt  = preset;
      // 1 Hz phase restarts here, not at the seconds edge
      nxt_st.hz   = 12'h000;
    end

    // ========================================================
    // Pin driver
    if (st_ff.tirq) begin
      nxt_st.rtn = 20'(st_ff.rtn - 20'h00001);
      if (st_ff.rtn == 20'h00001) begin
        nxt_st.tirq = 1'b0;
      end
    end
    if (!st_ff.timer_interrupt_enable) begin
      nxt_st.tirq = 1'b0;
    end
    if (ev && st_ff.timer_interrupt_enable) begin
      nxt_st.tirq = 1'b1;
      nxt_st.rtn  = (st_ff.tsel == 2'b00) ? 20'(RTN_SHORT) : 20'(RTN_LONG);
    end

    // ========================================================
    // AXI write
    if (s_axi_awvalid && st_ff.awr) begin
      nxt_st.aw_h = 1'b1;
      nxt_st.awr  = 1'b0;
      nxt_st.aw_i = s_axi_awaddr[5:2];
      hit         = (s_axi_awaddr[7:6] == 2'b00) && (s_axi_awaddr[1:0] == 2'b00);
      nxt_st.berr = !hit || (s_axi_awaddr[5:2] < `FCT_IDX_PRE_LO);
    end
    if (s_axi_wvalid && st_ff.wr) begin
      nxt_st.w_h = 1'b1;
      nxt_st.wr  = 1'b0;
      nxt_st.wd  = s_axi_wdata[7:0];
      nxt_st.ws  = s_axi_wstrb[0];
    end
    if (st_ff.aw_h && st_ff.w_h) begin
      nxt_st.aw_h = 1'b0;
      nxt_st.w_h  = 1'b0;
      nxt_st.bv   = 1'b1;
      wdo = st_ff.ws && !st_ff.berr;
    end
    if (wdo) begin
      unique case (st_ff.aw_i)
        // byte layout; plain storage when unused
        `FCT_IDX_PRE_LO: begin
          nxt_st.pre_lo = st_ff.wd;
          // Stopped count follows the store, so readback acts as storage
          if (!st_ff.te) begin
            nxt_st.cnt[7:0] = st_ff.wd;
          end
        end
        `FCT_IDX_PRE_HI: begin
          nxt_st.pre_hi = st_ff.wd[3:0];
          if (!st_ff.te) begin
            nxt_st.cnt[11:8] = st_ff.wd[3:0];
          end
        end
        `FCT_IDX_EXT: begin
          nxt_st.te   = st_ff.wd[`FCT_BIT_TE];
          nxt_st.tsel = st_ff.wd[`FCT_BIT_TSEL_HI:`FCT_BIT_TSEL_LO];
          // stopping leaves the pin as it is
          if (!st_ff.wd[`FCT_BIT_TE]) begin
            nxt_st.run  = 1'b0;
            nxt_st.pend = 1'b0;
          end else if (!st_ff.te) begin
            nxt_st.pend = 1'b1;
          end
        end
        `FCT_IDX_FLAG: begin
          if (!st_ff.wd[`FCT_BIT_TF]) begin
            nxt_st.tf = 1'b0;
          end
        end
        `FCT_IDX_CTRL: begin
          nxt_st.timer_interrupt_enable  = st_ff.wd[`FCT_BIT_TIE];
          nxt_st.halt = st_ff.wd[`FCT_BIT_HALT];
          nxt_st.crst = st_ff.wd[`FCT_BIT_CRST];
        end
        default: nxt_st.tf = st_ff.tf;
      endcase
    end
    if (ev) begin
      nxt_st.tf = 1'b1;
    end
    if (st_ff.bv && s_axi_bready) begin
      nxt_st.bv  = 1'b0;
      nxt_st.awr = 1'b1;
      nxt_st.wr  = 1'b1;
    end

    // ========================================================
    // AXI read
    if (s_axi_arvalid && st_ff.arr) begin
      nxt_st.arr = 1'b0;
      nxt_st.rv  = 1'b1;
      hit = (s_axi_araddr[7:6] == 2'b00) && (s_axi_araddr[1:0] == 2'b00);
      unique case (s_axi_araddr[5:2])
        // preset while enabled, live count while stopped
        `FCT_IDX_PRE_LO: rv8 = st_ff.te ? st_ff.pre_lo : st_ff.cnt[7:0];
        `FCT_IDX_PRE_HI: rv8 = {4'h0, st_ff.te ? st_ff.pre_hi : st_ff.cnt[11:8]};
        `FCT_IDX_EXT:    rv8 = {3'h0, st_ff.te, 2'h0, st_ff.tsel};
        `FCT_IDX_FLAG:   rv8 = {3'h0, st_ff.tf, 4'h0};
        `FCT_IDX_CTRL:   rv8 = {3'h0, st_ff.timer_interrupt_enable, 2'h0, st_ff.halt, st_ff.crst};
        default:         hit = 1'b0;
      endcase
      nxt_st.rd   = hit ? rv8 : 8'h00;
      nxt_st.rerr = !hit;
    end
    if (st_ff.rv && s_axi_rready) begin
      nxt_st.rv  = 1'b0;
      nxt_st.arr = 1'b1;
    end

    nxt_st.oe = nxt_st.tirq || st_ff.oi2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff     <= '0;
      st_ff.awr <= 1'b1;
      st_ff.wr  <= 1'b1;
      st_ff.arr <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awr;
  assign s_axi_wready  = st_ff.wr;
  assign s_axi_bvalid  = st_ff.bv;
  assign s_axi_bresp   = st_ff.berr ? 2'b10 : 2'b00;
  assign s_axi_arready = st_ff.arr;
  assign s_axi_rvalid  = st_ff.rv;
  assign s_axi_rdata   = {24'h000000, st_ff.rd};
  assign s_axi_rresp   = st_ff.rerr ? 2'b10 : 2'b00;
  // Pin level is never driven high, only released
  assign irq_n_o       = 1'b0;
  assign irq_n_oe      = st_ff.oe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_EVENT_FLAG: assert property (ev |=> st_ff.tf)
    else $error("event did not set flag");
  AST_FLAG_HOLD: assert property (st_ff.tf && !(st_ff.aw_h && st_ff.w_h) |=> st_ff.tf)
    else $error("flag fell without a write");
  AST_RELOAD: assert property (ev |=> st_ff.cnt == $past(preset))
    else $error("no reload after event");
  AST_DECR: assert property (st_ff.run && src_tick && st_ff.cnt > 12'h001
    && !(st_ff.pend && sclk_fall) |=> st_ff.cnt == $past(st_ff.cnt) - 12'h001)
    else $error("count did not step");
  AST_HALT: assert property (stopped && !(st_ff.pend && sclk_fall)
    && !(st_ff.aw_h && st_ff.w_h)
    |=> $stable(st_ff.cnt) && !$past(ev))
    else $error("counted while halted");
  AST_START: assert property (st_ff.pend && sclk_fall |=> st_ff.run
    && st_ff.cnt == $past(preset))
    else $error("start not at serial clock fall");
  AST_PIN_LOW: assert property (ev && st_ff.timer_interrupt_enable |-> ##2 irq_n_oe)
    else $error("enabled event left pin released");
  AST_TIE_OFF: assert property (!st_ff.timer_interrupt_enable && !st_ff.oi2 |=> !irq_n_oe)
    else $error("disabled timer held pin");
  AST_OTHER: assert property (st_ff.oi2 |=> irq_n_oe)
    else $error("other source not passed");
  AST_RTN: assert property (st_ff.tirq && st_ff.rtn == 20'h00001 && !ev |=> !st_ff.tirq)
    else $error("no auto release");
  AST_TE_CLR: assert property (st_ff.tirq && st_ff.timer_interrupt_enable && st_ff.rtn > 20'h00001
    && !st_ff.te |=> st_ff.tirq)
    else $error("stop released pin");
  AST_WR_KEEP: assert property (st_ff.tirq && st_ff.timer_interrupt_enable && st_ff.rtn > 20'h00001
    && st_ff.aw_h && st_ff.w_h |=> st_ff.tirq)
    else $error("register write released pin");

  COV_EVENT: cover property (ev ##[1:50] st_ff.tirq);
  COV_START: cover property (st_ff.pend ##[1:100] st_ff.run);
  COV_READ: cover property (s_axi_arvalid && st_ff.arr ##1 st_ff.rv);
  COV_RELEASE: cover property (st_ff.tirq ##1 !st_ff.tirq);

endmodule

/* File: inc/fct_defines.svh */
/*
 * Register indices, field positions, reset values and timing counts
 * for the periodic countdown timer. Assumes a 100 MHz system clock.
 */
`ifndef FCT_DEFINES_SVH
`define FCT_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define FCT_IDX_PRE_LO   4'hB
`define FCT_IDX_PRE_HI   4'hC
`define FCT_IDX_EXT      4'hD
`define FCT_IDX_FLAG     4'hE
`define FCT_IDX_CTRL     4'hF

// ==========================================================
// Field positions
`define FCT_BIT_TE       4
`define FCT_BIT_TSEL_HI  1
`define FCT_BIT_TSEL_LO  0
`define FCT_BIT_TF       4
`define FCT_BIT_TIE      4
`define FCT_BIT_HALT     1
`define FCT_BIT_CRST     0

// ==========================================================
// Reset values
`define FCT_RST_BYTE     8'h00
`define FCT_RST_NIB      4'h0
`define FCT_RST_CNT      12'h000

// ==========================================================
// Timing
`define FCT_CLK_PS       10000
`define FCT_SRC_PER_PS   244140625
`define FCT_SRC_CYC      (`FCT_SRC_PER_PS / `FCT_CLK_PS)
`define FCT_RTN_SHORT_NS 122000
`define FCT_RTN_LONG_NS  7813000
// Divide first: the long time in ps would overflow a 32-bit int
`define FCT_RTN_SHORT_CYC (`FCT_RTN_SHORT_NS / (`FCT_CLK_PS / 1000))
`define FCT_RTN_LONG_CYC  (`FCT_RTN_LONG_NS / (`FCT_CLK_PS / 1000))
`define FCT_DIV64        6'd63
`define FCT_DIV1HZ       12'd4095
`define FCT_DIVMIN       6'd59

`endif

/* File: inc/fct_pkg.sv */
/*
 * Types for the periodic countdown timer.
 * Assumes fct_defines.svh supplies all numeric constants.
 */
package fct_pkg;

  // ==========================================================
  // Source clock select
  typedef enum logic [1:0] {
    FCT_SRC_4096HZ,
    FCT_SRC_64HZ,
    FCT_SRC_1HZ,
    FCT_SRC_1_60HZ
  } fct_src_e;

  typedef logic [11:0] fct_cnt_t;

endpackage

/* File: testbench/fct_link_model.sv */
/*
 * Serial host clock model for the timer bench.
 * Assumes the bench raises go once per register frame.
 */
`timescale 1ns/1ps

// ==========================================================
// Link clock source
module fct_link_model (
  // Frame request
  input  wire logic go,
  // Serial clock, still and high between frames
  output logic      serial_clk
);
  initial serial_clk = 1'b1;

  always @(posedge go) begin
    #37;
    repeat (16) begin
      #80 serial_clk = 1'b0;
      #80 serial_clk = 1'b1;
    end
  end
endmodule

/* File: testbench/test_fixed_cycle_timer_interrupt.sv */
/*
 * Self-checking bench for the periodic countdown timer.
 * Assumes fct_timer with shortened counts and the link model.
 */
`timescale 1ns/1ps
`include "fct_defines.svh"

module test_fixed_cycle_timer_interrupt;
  localparam int CYC = 4;
  localparam int RS  = 3;
  localparam int RL  = 16;

  // ==========================================================
  // Signals
  logic        aclk = 0, aresetn = 0, go = 0, other_irq = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 4'h1;
  logic        awready, wready, bvalid, arready, rvalid, serial_clk;
  logic        irq_n_o, irq_n_oe, pin;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] d;
  int          fail_count = 0, n_tests = 0, seed = 49339, n, w, p, s;
  int          mult[4] = '{1, 64, 4096, 245760};

  // Open drain pin with pull-up
  assign pin = irq_n_oe ? irq_n_o : 1'b1;
  always #5 aclk = ~aclk;

  fct_link_model u_link (.go(go), .serial_clk(serial_clk));

  fct_timer #(.CYC_4096(CYC), .RTN_SHORT(RS), .RTN_LONG(RL)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clk(serial_clk),
    .other_irq(other_irq), .irq_n_i(pin), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
  );

  // ==========================================================
  // Reporting
  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask

  // ==========================================================
  // AXI4-Lite master
  task automatic wr(input logic [3:0] idx, input logic [7:0] v);
    int i;
    logic [31:0] x;
    x = $random(seed);
    @(posedge aclk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {x[31:8], v};
    wstrb   <= {x[2:0], 1'b1};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (i == 50) begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [3:0] idx);
    int i;
    @(posedge aclk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 50) begin
      fail_count++;
      print_verdict();
    end
  endtask

  // Bounded wait for a pin enable level
  task automatic wait_oe(input logic lvl, output int c);
    c = 0;
    while (irq_n_oe !== lvl) begin
      @(posedge aclk);
      c++;
      if (c > 20000) begin
        fail_count++;
        print_verdict();
      end
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 11; i < 16; i++) begin
      rd(4'(i));
      chk(d, 0);
    end
    rd(4'h0);
    chk(r, 2'b10);
    wr(4'h0, 8'hFF);
    chk(r, 2'b10);
    p = ($random(seed) & 32'hFFE) + 1;
    wr(`FCT_IDX_PRE_LO, p[7:0]);
    wr(`FCT_IDX_PRE_HI, {4'hA, p[11:8]});
    rd(`FCT_IDX_PRE_LO);
    chk(d, p[7:0]);
    rd(`FCT_IDX_PRE_HI);
    chk(d, p[11:8]);
    for (int i = 0; i < 4; i++) begin
      wr(`FCT_IDX_EXT, 8'(i));
      rd(`FCT_IDX_EXT);
      chk(d, i);
    end
    // Pin timing and period at the three faster sources
    for (s = 0; s < 3; s++) begin
      p = (s == 2) ? 1 : 2 - s;
      wr(`FCT_IDX_EXT, 8'h00);
      wr(`FCT_IDX_PRE_LO, 8'(p));
      wr(`FCT_IDX_PRE_HI, 8'h00);
      wr(`FCT_IDX_CTRL, 8'h10);
      wr(`FCT_IDX_EXT, 8'(16 + s));
      go <= 1'b1;
      wait_oe(1, n);
      chk(n <= p * CYC * mult[s] + 40, 1);
      wait_oe(0, w);
      chk(w >= (s ? RL : RS) && w <= (s ? RL : RS) + 1, 1);
      wait_oe(1, n);
      chk(w + n, p * CYC * mult[s]);
      rd(`FCT_IDX_PRE_LO);
      chk(d, p);
      wr(`FCT_IDX_EXT, 8'h00);
      if (s == 1) begin
        // Long release time still running here
        chk(irq_n_oe, 1);
        wr(`FCT_IDX_CTRL, 8'h00);
        @(posedge aclk);
        chk(irq_n_oe, 0);
      end
      go <= 1'b0;
      // Let the frame finish, else the next go edge is missed
      repeat (260) @(posedge aclk);
      rd(`FCT_IDX_PRE_LO);
      w = d;
      rd(`FCT_IDX_PRE_LO);
      chk(d, w);
      rd(`FCT_IDX_FLAG);
      chk(d[4], 1);
      wr(`FCT_IDX_FLAG, 8'h10);
      rd(`FCT_IDX_FLAG);
      chk(d[4], 1);
      wr(`FCT_IDX_FLAG, 8'h00);
      rd(`FCT_IDX_FLAG);
      chk(d[4], 0);
    end
    // Shared pin held by another source
    wr(`FCT_IDX_CTRL, 8'h00);
    other_irq <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(pin, 0);
    other_irq <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(irq_n_oe, 0);
    // Halted counter makes no events
    wr(`FCT_IDX_CTRL, 8'h02);
    wr(`FCT_IDX_EXT, 8'h10);
    go <= 1'b1;
    repeat (200) @(posedge aclk);
    rd(`FCT_IDX_FLAG);
    chk(d[4], 0);
    print_verdict();
  end
endmodule
